/* File: rtl/dmc_consts.vh */
/*
 * Constants for the channel 0 transfer mode block: I/O register offsets,
 * mode field positions, mode codes and reset values.
 * Assumes inclusion by bare name from the design files under rtl/.
 */
`ifndef DMC_CONSTS_VH
`define DMC_CONSTS_VH

// i/o register offsets (8-bit i/o address)
`define DMC_OFS_SRC_LO      8'h20
`define DMC_OFS_SRC_HI      8'h21
`define DMC_OFS_SRC_BANK    8'h22
`define DMC_OFS_DST_LO      8'h23
`define DMC_OFS_DST_HI      8'h24
`define DMC_OFS_DST_BANK    8'h25
`define DMC_OFS_CNT_LO      8'h26
`define DMC_OFS_CNT_HI      8'h27
`define DMC_OFS_CTRL        8'h30
`define DMC_OFS_MODE        8'h31

// transfer mode register field positions
`define DMC_DM_HI           5
`define DMC_DM_LO           4
`define DMC_SM_HI           3
`define DMC_SM_LO           2
`define DMC_MEM_TIMING      1

// control register bits
`define DMC_CTRL_START      0
`define DMC_CTRL_BUSY       0
`define DMC_CTRL_REFUSED    1

// address mode codes, shared by source and destination
`define DMC_AM_INC          2'h0
`define DMC_AM_DEC          2'h1
`define DMC_AM_FIX          2'h2
`define DMC_AM_IO           2'h3

// request select codes on source address bits 17..16
`define DMC_REQ_EXT         2'h0
`define DMC_REQ_SER0        2'h1
`define DMC_REQ_SER1        2'h2
`define DMC_REQ_SEL_HI      17
`define DMC_REQ_SEL_LO      16

// reset values
`define DMC_MODE_RST        2'h0
`define DMC_TIMING_RST      1'h0
`define DMC_ADDR_RST        20'h00000
`define DMC_CNT_RST         16'h0000
`define DMC_BYTE_RST        8'h00

`endif

/* File: rtl/dmc_buf.v */
/*
 * Small flip-flop FIFO with valid/ready on both sides, two entries by
 * default. Sits between the read and write halves of each byte move.
 * Assumes one clock and an asynchronous active-low reset.
 */
module dmc_buf #(
    parameter W  = 8,
    parameter AW = 1
) (
    // clock and reset
    input  wire          clk_sys_i,
    input  wire          rst_b_i,
    // fill side
    input  wire          in_valid_i,
    output wire          in_ready_o,
    input  wire [W-1:0]  in_data_i,
    // drain side
    output wire          out_valid_o,
    input  wire          out_ready_i,
    output wire [W-1:0]  out_data_o
);
    localparam D = 1 << AW;

    reg  [W-1:0]  mem_q [0:D-1];
    reg  [AW-1:0] wr_ptr_q;
    reg  [AW-1:0] rd_ptr_q;
    reg  [AW:0]   fill_q;
    wire          push;
    wire          pop;
    integer       i;

    // honest flags straight from the fill count
    assign in_ready_o  = (fill_q != D[AW:0]);
    assign out_valid_o = (fill_q != {(AW+1){1'b0}});
    assign out_data_o  = mem_q[rd_ptr_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // pointers and count
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            fill_q   <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            if (push & ~pop)
                fill_q <= fill_q + {{AW{1'b0}}, 1'b1};
            else if (pop & ~push)
                fill_q <= fill_q - {{AW{1'b0}}, 1'b1};
        end
    end

    // storage, cleared so the drain side never shows unknowns
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (i = 0; i < D; i = i + 1)
                mem_q[i] <= {W{1'b0}};
        end else if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end
endmodule

/* File: rtl/dmc_top.v */
/*
 * Channel 0 transfer engine with its transfer mode register.
 * Assumes a CPU i/o port (address, read and write strobes) synchronous to
 * clk_sys_i, a bus arbiter answering bus_req_o with bus_grant_i, and a
 * memory/i/o bus that acknowledges each cycle with ack_i.
 */
// What this block does
// (RULE_01) destination field bits 5..4: inc, dec, fixed memory, or fixed i/o
// (RULE_02) reset clears destination field: memory, incrementing address
// (RULE_03) source field bits 3..2: inc, dec, fixed memory, or fixed i/o
// (RULE_04) only twelve combinations valid; reserved ones must not be programmed
// (RULE_05) memory-to-memory uses no request; bit 1 picks burst or cycle steal
// (RULE_06) burst keeps the bus continuously until byte count is zero
// (RULE_07) cycle steal hands the processor one bus cycle per byte moved
// (RULE_08) any i/o end: selected request paces each byte, timing bit ignored
// (RULE_09) reset clears the timing bit, so cycle steal is the default
// (RULE_10) i/o source: address bits 17..16 choose external or serial request
// (RULE_11) source address is twenty bits wide
// (RULE_12) each byte steps both addresses and decrements count, stop at zero
`include "dmc_consts.vh"

module dmc_top #(
    parameter AW = 20,
    parameter CW = 16
) (
    // clock and reset
    input  wire          clk_sys_i,
    input  wire          rst_b_i,
    // cpu i/o register port
    input  wire [7:0]    io_addr_i,
    input  wire          io_wr_i,
    input  wire          io_rd_i,
    input  wire [7:0]    io_wdata_i,
    output wire [7:0]    io_rdata_o,
    // bus ownership
    output wire          bus_req_o,
    input  wire          bus_grant_i,
    // bus cycle
    output wire          cyc_o,
    output wire          we_o,
    output wire          io_o,
    output wire [AW-1:0] adr_o,
    output wire [7:0]    dat_o,
    input  wire [7:0]    dat_i,
    input  wire          ack_i,
    // pacing requests
    input  wire          external_request_0_i,
    input  wire [1:0]    serial_receive_full_i,
    // status
    output wire          busy_o,
    output wire          done_o
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ARB  = 3'h1;
    localparam ST_RD   = 3'h2;
    localparam ST_WR   = 3'h3;
    localparam ST_GIVE = 3'h4;

    reg  [2:0]    state_q;
    reg  [2:0]    state_d;
    reg  [1:0]    dest_mode_q;
    reg  [1:0]    src_mode_q;
    reg           mem_timing_select_q;
    reg  [AW-1:0] ch0_source_address_q;
    reg  [AW-1:0] ch0_dest_address_q;
    reg  [CW-1:0] count_q;
    reg           refused_q;
    reg           done_q;
    reg  [7:0]    rdata_q;
    reg  [7:0]    rdata_d;
    wire          dest_mode_hi;
    wire          dest_mode_lo;
    wire          src_mode_hi;
    wire          src_mode_lo;
    wire          src_io;
    wire          dst_io;
    wire          io_paced;
    wire          combo_ok;
    wire          start;
    wire          cnt_zero;
    wire          pace_req;
    wire          byte_rd;
    wire          byte_wr;
    wire          buf_in_ready;
    wire          buf_out_valid;
    wire [7:0]    buf_out_data;
    wire [1:0]    req_sel;

    // next address for a given mode; fixed and i/o hold
    function [AW-1:0] step_addr;
        input [AW-1:0] a;
        input [1:0]    m;
        begin
            case (m)
                `DMC_AM_INC: step_addr = a + {{(AW-1){1'b0}}, 1'b1};
                `DMC_AM_DEC: step_addr = a - {{(AW-1){1'b0}}, 1'b1};
                default:     step_addr = a;
            endcase
        end
    endfunction

    // true when a mode code means an i/o end
    function is_io;
        input [1:0] m;
        begin
            is_io = (m == `DMC_AM_IO);
        end
    endfunction

    // mode field bits as named
    assign dest_mode_hi = dest_mode_q[1];
    assign dest_mode_lo = dest_mode_q[0];
    assign src_mode_hi  = src_mode_q[1];
    assign src_mode_lo  = src_mode_q[0];

    // (RULE_01) destination type decode
    assign dst_io = is_io(dest_mode_q);
    // (RULE_03) source type decode
    assign src_io = is_io(src_mode_q);
    // (RULE_08) any i/o end means request pacing
    assign io_paced = src_io | dst_io;

    // (RULE_04) reserved: fixed-memory or i/o dest with fixed or i/o source
    assign combo_ok = ~(dest_mode_hi & src_mode_hi);

    assign start    = io_wr_i & (io_addr_i == `DMC_OFS_CTRL)
                    & io_wdata_i[`DMC_CTRL_START] & (state_q == ST_IDLE);
    assign cnt_zero = (count_q == {CW{1'b0}});

    // (RULE_10) request select from source bank bits, only for i/o source
    assign req_sel = src_io ? ch0_source_address_q[`DMC_REQ_SEL_HI:`DMC_REQ_SEL_LO]
                            : `DMC_REQ_EXT;

    // reserved select code leaves the channel waiting, never moving
    assign pace_req = (req_sel == `DMC_REQ_EXT)  ? external_request_0_i :
                      (req_sel == `DMC_REQ_SER0) ? serial_receive_full_i[0] :
                      (req_sel == `DMC_REQ_SER1) ? serial_receive_full_i[1] :
                      1'b0;

    // transfer mode register, cleared at reset
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // (RULE_02) destination field reset
            dest_mode_q         <= `DMC_MODE_RST;
            src_mode_q          <= `DMC_MODE_RST;
            // (RULE_09) timing bit reset
            mem_timing_select_q <= `DMC_TIMING_RST;
        end else if (io_wr_i & (io_addr_i == `DMC_OFS_MODE) & (state_q == ST_IDLE)) begin
            dest_mode_q         <= io_wdata_i[`DMC_DM_HI:`DMC_DM_LO];
            src_mode_q          <= io_wdata_i[`DMC_SM_HI:`DMC_SM_LO];
            mem_timing_select_q <= io_wdata_i[`DMC_MEM_TIMING];
        end
    end

    // byte moves: read half fills the buffer, write half drains it
    assign byte_rd = (state_q == ST_RD) & ack_i;
    assign byte_wr = (state_q == ST_WR) & ack_i & buf_out_valid;

    // addresses and count; cpu writes only while idle, so one owner at a time
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ch0_source_address_q <= `DMC_ADDR_RST;
            ch0_dest_address_q   <= `DMC_ADDR_RST;
            count_q              <= `DMC_CNT_RST;
        end else if (state_q == ST_IDLE) begin
            if (io_wr_i) begin
                // (RULE_11) twenty-bit source address over three bytes
                case (io_addr_i)
                    `DMC_OFS_SRC_LO:   ch0_source_address_q[7:0]   <= io_wdata_i;
                    `DMC_OFS_SRC_HI:   ch0_source_address_q[15:8]  <= io_wdata_i;
                    `DMC_OFS_SRC_BANK: ch0_source_address_q[19:16] <= io_wdata_i[3:0];
                    `DMC_OFS_DST_LO:   ch0_dest_address_q[7:0]     <= io_wdata_i;
                    `DMC_OFS_DST_HI:   ch0_dest_address_q[15:8]    <= io_wdata_i;
                    `DMC_OFS_DST_BANK: ch0_dest_address_q[19:16]   <= io_wdata_i[3:0];
                    `DMC_OFS_CNT_LO:   count_q[7:0]                <= io_wdata_i;
                    `DMC_OFS_CNT_HI:   count_q[15:8]               <= io_wdata_i;
                    default:           count_q                     <= count_q;
                endcase
            end
        end else begin
            // (RULE_12) step source after read
            if (byte_rd)
                ch0_source_address_q <= step_addr(ch0_source_address_q, src_mode_q);
            // (RULE_12) step destination and count after write
            if (byte_wr) begin
                ch0_dest_address_q <= step_addr(ch0_dest_address_q, dest_mode_q);
                count_q            <= count_q - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // transfer sequencer
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start & combo_ok & ~cnt_zero)
                    state_d = ST_ARB;
            end
            ST_ARB: begin
                // (RULE_05) memory-to-memory needs only the grant
                // (RULE_08) i/o transfers also wait for the request
                if (bus_grant_i & buf_in_ready & (~io_paced | pace_req))
                    state_d = ST_RD;
            end
            ST_RD: begin
                if (ack_i)
                    state_d = ST_WR;
            end
            ST_WR: begin
                if (byte_wr) begin
                    if (count_q == {{(CW-1){1'b0}}, 1'b1})
                        // (RULE_12) stop when count reaches zero
                        state_d = ST_IDLE;
                    else if (io_paced)
                        state_d = ST_ARB;
                    else if (mem_timing_select_q)
                        // (RULE_06) burst keeps the bus
                        state_d = ST_ARB;
                    else
                        // (RULE_07) cycle steal yields a cycle
                        state_d = ST_GIVE;
                end
            end
            ST_GIVE: begin
                state_d = ST_ARB;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // refused start and done pulse
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            refused_q <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            // (RULE_04) a reserved combination never starts
            if (start)
                refused_q <= ~combo_ok;
            done_q <= (state_q != ST_IDLE) & (state_d == ST_IDLE);
        end
    end

    // (RULE_06) bus request stays up between bytes in burst
    // (RULE_07) request drops in the give cycle for the processor
    assign bus_req_o = (state_q == ST_RD) | (state_q == ST_WR)
                     | ((state_q == ST_ARB) & (~io_paced | pace_req));

    // bus cycle outputs, muxed from held registers
    assign cyc_o = (state_q == ST_RD) | ((state_q == ST_WR) & buf_out_valid);
    assign we_o  = (state_q == ST_WR);
    assign io_o  = (state_q == ST_WR) ? dst_io : src_io;
    assign adr_o = (state_q == ST_WR) ? ch0_dest_address_q : ch0_source_address_q;
    assign dat_o = buf_out_data;

    // read side: the bus may stall the write half; the buffer absorbs it
    dmc_buf #(
        .W  (8),
        .AW (1)
    ) u_buf (
        .clk_sys_i   (clk_sys_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (byte_rd),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (dat_i),
        .out_valid_o (buf_out_valid),
        .out_ready_i (byte_wr),
        .out_data_o  (buf_out_data)
    );

    // register read mux; reserved bits read as zero
    always @* begin
        rdata_d = `DMC_BYTE_RST;
        case (io_addr_i)
            `DMC_OFS_SRC_LO:   rdata_d = ch0_source_address_q[7:0];
            `DMC_OFS_SRC_HI:   rdata_d = ch0_source_address_q[15:8];
            `DMC_OFS_SRC_BANK: rdata_d = {4'h0, ch0_source_address_q[19:16]};
            `DMC_OFS_DST_LO:   rdata_d = ch0_dest_address_q[7:0];
            `DMC_OFS_DST_HI:   rdata_d = ch0_dest_address_q[15:8];
            `DMC_OFS_DST_BANK: rdata_d = {4'h0, ch0_dest_address_q[19:16]};
            `DMC_OFS_CNT_LO:   rdata_d = count_q[7:0];
            `DMC_OFS_CNT_HI:   rdata_d = count_q[15:8];
            `DMC_OFS_CTRL: begin
                rdata_d[`DMC_CTRL_BUSY]    = (state_q != ST_IDLE);
                rdata_d[`DMC_CTRL_REFUSED] = refused_q;
            end
            `DMC_OFS_MODE: begin
                rdata_d[`DMC_DM_HI]      = dest_mode_hi;
                rdata_d[`DMC_DM_LO]      = dest_mode_lo;
                rdata_d[`DMC_SM_HI]      = src_mode_hi;
                rdata_d[`DMC_SM_LO]      = src_mode_lo;
                rdata_d[`DMC_MEM_TIMING] = mem_timing_select_q;
            end
            default:           rdata_d = `DMC_BYTE_RST;
        endcase
    end

    // read data held until the next read strobe
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i)
            rdata_q <= `DMC_BYTE_RST;
        else if (io_rd_i)
            rdata_q <= rdata_d;
    end

    assign io_rdata_o = rdata_q;
    assign busy_o     = (state_q != ST_IDLE);
    assign done_o     = done_q;
endmodule

/* File: tb/dmc_chk.sv */
/*
 * Checker for the channel 0 transfer engine: bus ordering, pacing, timing
 * modes and mode register readback, bound into dmc_top.
 * Assumes the port timing of dmc_top and one clock domain.
 */
`include "dmc_consts.vh"

module dmc_chk #(
    parameter AW = 20,
    parameter CW = 16
) (
    // clock and reset
    input wire logic          clk_sys_i,
    input wire logic          rst_b_i,
    // register port
    input wire logic [7:0]    io_addr_i,
    input wire logic          io_wr_i,
    input wire logic          io_rd_i,
    input wire logic [7:0]    io_wdata_i,
    input wire logic [7:0]    io_rdata_o,
    // bus side
    input wire logic          bus_req_o,
    input wire logic          cyc_o,
    input wire logic          we_o,
    input wire logic          io_o,
    input wire logic [AW-1:0] adr_o,
    input wire logic          ack_i,
    input wire logic          external_request_0_i,
    // status
    input wire logic          busy_o,
    input wire logic          done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] mode_q;
    wire        mm = (mode_q[5:4] != 2'h3) && (mode_q[3:2] != 2'h3);

    // shadow of the mode register; writes while busy are dropped
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_q <= 6'h00;
        end else if (io_wr_i && io_addr_i == `DMC_OFS_MODE && !busy_o) begin
            mode_q <= io_wdata_i[5:0] & 6'h3E;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    a_mode_readback: assert property (io_rd_i && io_addr_i == `DMC_OFS_MODE
        |=> io_rdata_o == {2'b00, mode_q}) else $error("mode readback wrong");
    a_burst_keeps_bus: assert property (busy_o && mm && mode_q[1] && bus_req_o
        |=> bus_req_o || !busy_o) else $error("burst let go of the bus");
    a_steal_gives_cpu: assert property (busy_o && mm && !mode_q[1] && cyc_o && we_o
        && ack_i |=> !bus_req_o ##1 (bus_req_o || !busy_o))
        else $error("no cpu cycle in steal");
    a_paced_by_req: assert property ($rose(cyc_o) && mode_q[5:4] == 2'h3
        |-> $past(external_request_0_i)) else $error("i/o move without request");
    a_space_select: assert property (cyc_o
        |-> io_o == (we_o ? mode_q[5:4] == 2'h3 : mode_q[3:2] == 2'h3))
        else $error("wrong address space");
    a_read_first: assert property ($rose(cyc_o) |-> !we_o)
        else $error("byte began with write");
    a_cycle_holds: assert property (cyc_o && !ack_i
        |=> cyc_o && $stable(adr_o) && $stable(we_o)) else $error("cycle changed before ack");
    a_done_after_wr: assert property (done_o
        |-> $past(cyc_o && we_o && ack_i) && !busy_o) else $error("done without final write");
    a_reserved_refused: assert property (io_wr_i && io_addr_i == `DMC_OFS_CTRL
        && io_wdata_i[0] && !busy_o && mode_q[5] && mode_q[3] |=> !busy_o)
        else $error("reserved mode started");
    a_idle_no_bus: assert property (!busy_o |-> !bus_req_o && !cyc_o)
        else $error("bus used idle");
endmodule

bind dmc_top dmc_chk #(.AW(AW), .CW(CW)) u_chk (.clk_sys_i, .rst_b_i, .io_addr_i, .io_wr_i,
    .io_rd_i, .io_wdata_i, .io_rdata_o, .bus_req_o, .cyc_o, .we_o, .io_o, .adr_o, .ack_i,
    .external_request_0_i, .busy_o, .done_o);

/* File: tb/dmc_mem.sv */
/*
 * Far-side model: bus arbiter plus byte memory and i/o space, 512 bytes.
 * Assumes the engine holds each cycle until it sees ack_o high.
 */
module dmc_mem (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    // bus from the engine
    input  wire logic        req_i,
    input  wire logic        cyc_i,
    input  wire logic        we_i,
    input  wire logic        io_i,
    input  wire logic [19:0] adr_i,
    input  wire logic [7:0]  wdat_i,
    input  wire logic        slow_i,
    // answers
    output logic             grant_o,
    output logic             ack_o,
    output logic [7:0]       rdat_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  mem [0:511];
    logic [19:0] last_rd_q;
    logic [1:0]  wait_q;

    // grant follows request a cycle late; slow mode adds two wait states
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            grant_o <= 1'b0;
            ack_o <= 1'b0;
            wait_q <= 2'h0;
            rdat_o <= 8'hFF;
        end else begin
            grant_o <= req_i;
            ack_o <= 1'b0;
            rdat_o <= ~rdat_o; // data line is garbage outside an answer
            if (cyc_i && !ack_o) begin
                if (wait_q == (slow_i ? 2'h2 : 2'h0)) begin
                    ack_o <= 1'b1;
                    wait_q <= 2'h0;
                    if (we_i) begin
                        mem[{io_i, adr_i[7:0]}] <= wdat_i;
                    end else begin
                        rdat_o <= mem[{io_i, adr_i[7:0]}];
                        last_rd_q <= adr_i;
                    end
                end else begin
                    wait_q <= wait_q + 2'h1;
                end
            end
        end
    end
endmodule

/* File: tb/tb.sv */
/*
 * Testbench for dmc_top: register access tasks, transfer scenarios with a
 * reference copy of memory, and the closing report.
 * Assumes dmc_mem as bus partner and the bound checker.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [7:0]  io_addr_i = 8'h00;
    logic        io_wr_i = 1'b0;
    logic        io_rd_i = 1'b0;
    logic [7:0]  io_wdata_i = 8'h00;
    logic [2:0]  req = 3'h0;
    logic        slow = 1'b0;
    wire  [7:0]  io_rdata_o, dat_o, dat_i;
    wire  [19:0] adr_o;
    wire         bus_req_o, bus_grant_i, cyc_o, we_o, io_o, ack_i, busy_o, done_o;
    logic [7:0]  ref_m [0:511];
    int          n_errors = 0;
    int          comparisons = 0;

    // 20 MHz system clock
    always #25 clk_sys_i = ~clk_sys_i;

    dmc_top DUT (.clk_sys_i, .rst_b_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
        .bus_req_o, .bus_grant_i, .cyc_o, .we_o, .io_o, .adr_o, .dat_o, .dat_i, .ack_i,
        .external_request_0_i(req[0]), .serial_receive_full_i(req[2:1]), .busy_o, .done_o);
    dmc_mem u_mem (.clk_sys_i, .rst_b_i, .req_i(bus_req_o), .cyc_i(cyc_o), .we_i(we_o),
        .io_i(io_o), .adr_i(adr_o), .wdat_i(dat_o), .slow_i(slow), .grant_o(bus_grant_i),
        .ack_o(ack_i), .rdat_o(dat_i));

    task automatic results;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one write strobe, then a quiet cycle before the next access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        io_addr_i = a;
        io_wdata_i = d;
        io_wr_i = 1'b1;
        @(negedge clk_sys_i);
        io_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys_i);
        io_addr_i = a;
        io_rd_i = 1'b1;
        @(negedge clk_sys_i);
        io_rd_i = 1'b0;
        chk({12'h000, io_rdata_o}, {12'h000, exp});
    endtask

    function automatic logic [19:0] st(input logic [1:0] m);
        return (m == 2'h0) ? 20'h00001 : (m == 2'h1) ? 20'hFFFFF : 20'h00000;
    endfunction

    // program, run and check one transfer; requests rise a few cycles late
    task automatic xfer(input logic [7:0] md, input logic [19:0] sa, input logic [19:0] da,
                        input logic [7:0] n, input logic sl, input logic [2:0] rq);
        logic [19:0] s, d, last;
        logic        sio, dio, mm, seen;
        int          gives, k;
        sio = (md[3:2] == 2'h3);
        dio = (md[5:4] == 2'h3);
        mm = !sio && !dio;
        seen = 1'b0;
        gives = 0;
        slow = sl;
        req = 3'h0;
        wr(8'h20, sa[7:0]);
        wr(8'h21, sa[15:8]);
        wr(8'h22, {4'h0, sa[19:16]});
        wr(8'h23, da[7:0]);
        wr(8'h24, da[15:8]);
        wr(8'h25, {4'h0, da[19:16]});
        wr(8'h26, n);
        wr(8'h27, 8'h00);
        wr(8'h31, md);
        wr(8'h30, 8'h01);
        for (k = 0; k < 2000 && (busy_o !== 1'b0 || k < 2); k++) begin
            @(negedge clk_sys_i);
            if (k == 6 && !mm) chk({19'h0, bus_req_o}, 20'h0);
            if (k == 6) req = rq;
            if (busy_o && !bus_req_o) gives++;
            seen = seen | done_o;
        end
        if (busy_o !== 1'b0) begin
            n_errors++;
            $display("BAD %0t transfer hung", $time);
            results();
        end
        chk({19'h0, seen}, 20'h1);
        if (mm) chk(20'(gives), md[1] ? 20'h0 : 20'(n - 1));
        s = sa;
        d = da;
        for (k = 0; k < n; k++) begin
            ref_m[{dio, d[7:0]}] = ref_m[{sio, s[7:0]}];
            last = s;
            s = s + st(md[3:2]);
            d = d + st(md[5:4]);
        end
        chk(u_mem.last_rd_q, last);
        d = da;
        for (k = 0; k < n; k++) begin
            chk({12'h0, u_mem.mem[{dio,d[7:0]}]}, {12'h0, ref_m[{dio,d[7:0]}]});
            d = d + st(md[5:4]);
        end
    endtask

    // main sequence
    initial begin
        for (int k = 0; k < 512; k++) begin
            ref_m[k] = 8'(k ^ (k >> 3));
            u_mem.mem[k] = 8'(k ^ (k >> 3));
        end
        repeat (2) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        rd(8'h31, 8'h00);
        wr(8'h31, 8'hFF);
        rd(8'h31, 8'h3E);
        rd(8'h3F, 8'h00);
        rst_b_i = 1'b0;
        @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        rd(8'h31, 8'h00);
        wr(8'h26, 8'h02);
        wr(8'h31, 8'h28);
        wr(8'h30, 8'h01);
        rd(8'h30, 8'h02);
        wr(8'h31, 8'h3C);
        wr(8'h30, 8'h01);
        rd(8'h30, 8'h02);
        // only valid combinations from here on
        xfer(8'h00, 20'h00010, 20'h00080, 8'h03, 1'b0, 3'h0);
        // a valid start clears the refused flag
        rd(8'h30, 8'h00);
        xfer(8'h02, 20'h0FFFE, 20'h00090, 8'h04, 1'b1, 3'h0);
        xfer(8'h16, 20'h0001F, 20'h000AF, 8'h03, 1'b0, 3'h0);
        xfer(8'h08, 20'h00020, 20'h000B0, 8'h02, 1'b1, 3'h0);
        xfer(8'h22, 20'h00021, 20'h000C0, 8'h03, 1'b0, 3'h0);
        xfer(8'h0C, 20'h10005, 20'h000D0, 8'h02, 1'b0, 3'h2);
        xfer(8'h1C, 20'h20006, 20'h000DF, 8'h02, 1'b1, 3'h4);
        xfer(8'h0E, 20'h00007, 20'h000E0, 8'h01, 1'b0, 3'h1);
        xfer(8'h32, 20'hF0030, 20'h00050, 8'h02, 1'b0, 3'h1);
        xfer(8'h34, 20'h0003A, 20'h00060, 8'h02, 1'b1, 3'h1);
        results();
    end
endmodule
